// >>> hdl/chip_select_decoder.sv
// address decoder producing the three chip selects
`timescale 1ns/1ns
`default_nettype none
module chip_select_decoder
	import ext_bus_pkg::*;
(
	// configuration
	input  wire bus_mode_t   bus_mode,
	input  wire logic        external_rom_mode,
	input  wire dec_size_t   dec_size,
	// address under decode
	input  wire logic [23:0] addr,
	// one-hot hits, active high
	output logic [2:0]       hit
);
	function automatic logic in_range(input logic [23:0] a,
		input logic [23:0] lo, input logic [23:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	logic [23:0] blk;

	always_comb begin
		hit = 3'h0;
		blk = BLK_8K;
		case (bus_mode)
		MODE_64K: begin
			if (!external_rom_mode) begin
				case (dec_size)
				SIZE_8K: begin
					hit[0] = in_range(addr, MCU_WIN_LO, 24'h00_9fff);
					hit[1] = in_range(addr, 24'h00_a000, 24'h00_bfff);
					hit[2] = in_range(addr, 24'h00_c000, 24'h00_dfff);
				end
				SIZE_16K: begin
					hit[0] = in_range(addr, MCU_EXT_LO, 24'h00_afff);
					hit[1] = in_range(addr, 24'h00_b000, EXT64_TOP);
				end
				SIZE_32K: hit[0] = in_range(addr, MCU_WIN_LO, EXT64_TOP);
				default: hit = 3'h0;
				endcase
			end else begin
				case (dec_size)
				SIZE_8K: blk = BLK_8K;
				SIZE_16K: blk = BLK_16K_MCU;
				SIZE_32K: blk = MCU_WIN_LO;
				default: blk = INT_RAM_LO;
				endcase
				// consecutive equal blocks from zero, capped at top
				for (int i = 0; i < SEL_N; i++) begin
					hit[i] = (addr <= EXT64_TOP) &&
						(addr >= 24'(blk * 24'(i))) &&
						(addr < 24'(blk * 24'(i + 1)));
				end
			end
		end
		MODE_4M_MIN, MODE_4M_MAX: begin
			hit[1] = in_range(addr, SEL1_LO, SEL1_HI);
			hit[2] = in_range(addr, SEL2_LO, SEL2_HI);
			if (!external_rom_mode)
				hit[0] = addr >= SEL0_MCU_LO;
			else
				hit[0] = in_range(addr, 24'h00_0000, EXT64_TOP) ||
					in_range(addr, SEL0_MPU_LO2, SEL0_MPU_HI);
		end
		default: hit = 3'h0;
		endcase
		if (in_range(addr, INT_RAM_LO, INT_RAM_HI))
			hit = 3'h0;
	end
endmodule
`default_nettype wire

// >>> hdl/ext_bus_pkg.sv
// constants for the external memory bus interface
package ext_bus_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 8;
	localparam int ADDR_LOW_W = 16;
	localparam int SEL_N = 3;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_64K,
		MODE_4M_MIN,
		MODE_4M_MAX
	} bus_mode_t;

	// decoder size choice, 64K mode only
	typedef enum logic [1:0] {
		SIZE_8K,
		SIZE_16K,
		SIZE_32K,
		SIZE_64K
	} dec_size_t;

	// wait state counts per choice; one state is half a clock
	localparam logic [3:0] WAIT_STATES_0 = 4'h0;
	localparam logic [3:0] WAIT_STATES_1 = 4'h4;
	localparam logic [3:0] WAIT_STATES_2 = 4'h8;
	localparam logic [3:0] WAIT_STATES_3 = 4'hc;
	localparam int STATES_PER_CLOCK = 2;

	// 24-bit address space boundaries
	localparam logic [23:0] INT_RAM_LO = 24'h00_f000;
	localparam logic [23:0] INT_RAM_HI = 24'h00_ffff;
	localparam logic [23:0] MCU_EXT_LO = 24'h00_7000;
	localparam logic [23:0] MCU_WIN_LO = 24'h00_8000;
	localparam logic [23:0] EXT64_TOP = 24'h00_efff;
	localparam logic [23:0] SEL1_LO = 24'h40_0000;
	localparam logic [23:0] SEL2_LO = 24'h80_0000;
	localparam logic [23:0] SEL0_MCU_LO = 24'hc0_0000;
	localparam logic [23:0] SEL0_MPU_HI = 24'h3f_ffff;
	localparam logic [23:0] SEL0_MPU_LO2 = 24'h01_0000;
	localparam logic [23:0] SEL2_HI = 24'hbf_ffff;
	localparam logic [23:0] SEL1_HI = 24'h7f_ffff;
	localparam logic [23:0] BLK_8K = 24'h00_2000;
	localparam logic [23:0] BLK_16K_MCU = 24'h00_4000;

	// port reset values
	localparam logic [21:0] PORT_ADDR_RST = 22'h00_0000;
	localparam logic [1:0] PORT_STROBE_RST = 2'h3;
	localparam logic [2:0] PORT_SEL_RST = 3'h7;
endpackage

// >>> hdl/ext_memory_bus.sv
// external memory bus interface: pin sharing, strobes, selects, waits
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 22 address terminals shared with three output port groups by mode
// - single chip: all 22 terminals are port outputs, no address
// - 64K mode: low 16 carry address, upper 6 stay port outputs
// - both 4M modes: all 22 terminals carry address
// - ports taken by bus keep readable writable data and hi-z registers
// - read/write strobe pins are ports in single chip, strobes otherwise
// - strobes assert only on external area accesses
// - internal decoder yields three active-low chip selects
// - selects individually enabled in expanded modes, ports in single chip
// - chip selects assert only during external memory access
// - halt or sleep forces all chip selects high
// - 64K internal ROM select ranges per size
// - 64K external ROM selects from zero, equal blocks, top 00EFFF
// - 4M select ranges for internal and external ROM
// - bus mode sets select sizes; 64K offers four size choices with external ROM, three with internal ROM
// - software wait count choices 0, 4, 8 or 12 states
// - each wait state lasts half a clock
// - waits sit between third and fourth bus states
// - no waits on internal access, low-speed clock, or single chip
// - data pins are port in single chip, data bus when expanded
// - four bus modes; single chip barred with external ROM; reset loads single chip regardless
// - 00F000-00FFFF never decoded as external
module ext_memory_bus
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// static configuration
	input  wire ext_bus_pkg::bus_mode_t requested_mode,
	input  wire logic                 external_rom_mode,
	input  wire logic [2:0]           select_enable,
	input  wire ext_bus_pkg::dec_size_t dec_size,
	input  wire logic [1:0]           wait_choice,
	input  wire logic                 low_speed_osc_clock,
	input  wire logic                 cpu_standby,
	// cpu access
	input  wire logic                 access_start,
	input  wire logic                 access_write,
	input  wire logic [23:0]          access_addr,
	input  wire logic [7:0]           access_wdata,
	output logic                      access_done,
	output logic [7:0]                access_rdata,
	// port register writes and readback
	input  wire logic                 port_addr_we,
	input  wire logic [21:0]          port_addr_wdata,
	input  wire logic                 port_addr_hiz_we,
	input  wire logic [21:0]          port_addr_hiz_wdata,
	input  wire logic                 port_ctl_we,
	input  wire logic [4:0]           port_ctl_wdata,
	input  wire logic                 port_ctl_hiz_we,
	input  wire logic [4:0]           port_ctl_hiz_wdata,
	input  wire logic                 io_port_we,
	input  wire logic [7:0]           io_port_wdata,
	input  wire logic                 io_port_dir_we,
	input  wire logic [7:0]           io_port_dir_wdata,
	output logic [21:0]               port_addr_data,
	output logic [21:0]               port_addr_hiz,
	output logic [4:0]                port_ctl_data,
	output logic [4:0]                port_ctl_hiz,
	output logic [7:0]                io_port_data,
	output logic [7:0]                io_port_dir,
	output ext_bus_pkg::bus_mode_t    bus_mode,
	// pins
	output logic [21:0]               ext_addr_lines,
	output logic [21:0]               ext_addr_lines_oe,
	output logic                      out_port_read_pin,
	output logic                      out_port_write_pin,
	output logic [1:0]                strobe_pins_oe,
	output logic                      chip_select_zero_n,
	output logic                      chip_select_one_n,
	output logic                      chip_select_two_n,
	output logic [2:0]                select_pins_oe,
	input  wire logic [7:0]           ext_data_lines_in,
	output logic [7:0]                ext_data_lines_out,
	output logic [7:0]                ext_data_lines_oe
);
	typedef enum {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_WAIT,
		ST_T4
	} bus_state_t;

	bus_state_t state;
	logic [2:0] hit;
	logic [2:0] sel_hit;
	logic       ext_access;
	logic       expanded;
	logic       wait_busy;
	logic [3:0] wait_states;
	logic       start_wait;
	logic [23:0] cur_addr;
	logic        cur_write;
	logic [7:0]  cur_wdata;
	logic [2:0]  cur_hit;
	logic        cur_ext;

	// a single chip request is refused while running from external ROM; reset loads single chip regardless
	always_ff @(posedge clock) begin
		if (reset)
			bus_mode <= MODE_SINGLE;
		else if (!(requested_mode == MODE_SINGLE && external_rom_mode))
			bus_mode <= requested_mode;
	end

	assign expanded = bus_mode != MODE_SINGLE;

	chip_select_decoder u_decoder (
		.bus_mode          (bus_mode),
		.external_rom_mode (external_rom_mode),
		.dec_size          (dec_size),
		.addr              (access_addr),
		.hit               (hit)
	);

	assign sel_hit = hit & select_enable;
	// both 4M modes also treat any address above the first 64K as external
	assign ext_access = expanded && (hit != 3'h0 ||
		(bus_mode != MODE_64K && access_addr[23:16] != 8'h00));

	// port registers always remain general storage
	always_ff @(posedge clock) begin
		if (reset) begin
			port_addr_data <= PORT_ADDR_RST;
			port_addr_hiz  <= PORT_ADDR_RST;
		end else begin
			if (port_addr_we)
				port_addr_data <= port_addr_wdata;
			if (port_addr_hiz_we)
				port_addr_hiz <= port_addr_hiz_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			port_ctl_data <= {PORT_SEL_RST, PORT_STROBE_RST};
			port_ctl_hiz  <= 5'h00;
			io_port_data  <= 8'h00;
			io_port_dir   <= 8'h00;
		end else begin
			if (port_ctl_we)
				port_ctl_data <= port_ctl_wdata;
			if (port_ctl_hiz_we)
				port_ctl_hiz <= port_ctl_hiz_wdata;
			if (io_port_we)
				io_port_data <= io_port_wdata;
			if (io_port_dir_we)
				io_port_dir <= io_port_dir_wdata;
		end
	end

	// bus cycle sequencer
	always_ff @(posedge clock) begin
		if (reset) begin
			state     <= ST_IDLE;
			cur_addr  <= 24'h00_0000;
			cur_write <= 1'b0;
			cur_wdata <= 8'h00;
			cur_hit   <= 3'h0;
			cur_ext   <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (access_start) begin
					state     <= ST_T1;
					cur_addr  <= access_addr;
					cur_write <= access_write;
					cur_wdata <= access_wdata;
					cur_hit   <= sel_hit;
					cur_ext   <= ext_access;
				end
			end
			ST_T1: state <= ST_T2;
			ST_T2: state <= ST_T3;
			ST_T3: state <= start_wait ? ST_WAIT : ST_T4;
			ST_WAIT: begin
				if (!wait_busy)
					state <= ST_T4;
			end
			ST_T4: state <= ST_IDLE;
			default: state <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		case (wait_choice)
		2'h0: wait_states = WAIT_STATES_0;
		2'h1: wait_states = WAIT_STATES_1;
		2'h2: wait_states = WAIT_STATES_2;
		default: wait_states = WAIT_STATES_3;
		endcase
	end

	assign start_wait = state == ST_T3 && cur_ext && expanded &&
		!low_speed_osc_clock && wait_states != 4'h0;

	wait_counter u_wait (
		.clock  (clock),
		.reset  (reset),
		.start  (start_wait),
		.states (wait_states),
		.busy   (wait_busy)
	);

	assign access_done = state == ST_T4;

	always_ff @(posedge clock) begin
		if (reset)
			access_rdata <= 8'h00;
		else if (!cur_write && cur_ext && ((state == ST_T3 && !start_wait) ||
			(state == ST_WAIT && !wait_busy)))
			// take read data at the end of the waits, for slow devices
			access_rdata <= ext_data_lines_in;
	end

	// address and port pin muxing
	always_ff @(posedge clock) begin
		if (reset) begin
			ext_addr_lines    <= PORT_ADDR_RST;
			ext_addr_lines_oe <= PORT_ADDR_RST;
		end else begin
			for (int i = 0; i < ADDR_W; i++) begin
				if ((bus_mode == MODE_64K && i < ADDR_LOW_W) ||
					bus_mode == MODE_4M_MIN ||
					bus_mode == MODE_4M_MAX) begin
					ext_addr_lines[i]    <= cur_addr[i];
					ext_addr_lines_oe[i] <= 1'b1;
				end else begin
					ext_addr_lines[i]    <= port_addr_data[i];
					ext_addr_lines_oe[i] <= !port_addr_hiz[i];
				end
			end
		end
	end

	// strobes, selects and data
	always_ff @(posedge clock) begin
		if (reset) begin
			out_port_read_pin  <= 1'b1;
			out_port_write_pin <= 1'b1;
			strobe_pins_oe     <= 2'h0;
			chip_select_zero_n <= 1'b1;
			chip_select_one_n  <= 1'b1;
			chip_select_two_n  <= 1'b1;
			select_pins_oe     <= 3'h0;
			ext_data_lines_out <= 8'h00;
			ext_data_lines_oe  <= 8'h00;
		end else if (!expanded) begin
			out_port_read_pin  <= port_ctl_data[0];
			out_port_write_pin <= port_ctl_data[1];
			strobe_pins_oe     <= ~port_ctl_hiz[1:0];
			chip_select_zero_n <= port_ctl_data[2];
			chip_select_one_n  <= port_ctl_data[3];
			chip_select_two_n  <= port_ctl_data[4];
			select_pins_oe     <= ~port_ctl_hiz[4:2];
			ext_data_lines_out <= io_port_data;
			ext_data_lines_oe  <= io_port_dir;
		end else begin
			out_port_read_pin  <= !(cur_ext && !cur_write &&
				state inside {ST_T2, ST_T3, ST_WAIT});
			out_port_write_pin <= !(cur_ext && cur_write &&
				state inside {ST_T3, ST_WAIT});
			strobe_pins_oe     <= 2'h3;
			for (int i = 0; i < SEL_N; i++) begin
				if (select_enable[i])
					select_pins_oe[i] <= 1'b1;
				else
					select_pins_oe[i] <= !port_ctl_hiz[i + 2];
			end
			chip_select_zero_n <= select_enable[0] ? !(cur_hit[0] &&
				state != ST_IDLE && !cpu_standby) : port_ctl_data[2];
			chip_select_one_n  <= select_enable[1] ? !(cur_hit[1] &&
				state != ST_IDLE && !cpu_standby) : port_ctl_data[3];
			chip_select_two_n  <= select_enable[2] ? !(cur_hit[2] &&
				state != ST_IDLE && !cpu_standby) : port_ctl_data[4];
			ext_data_lines_out <= cur_wdata;
			ext_data_lines_oe  <= {8{cur_ext && cur_write &&
				state inside {ST_T2, ST_T3, ST_WAIT}}};
		end
	end
endmodule
`default_nettype wire

// >>> hdl/wait_counter.sv
// counts inserted wait states between third and fourth bus states
`timescale 1ns/1ns
`default_nettype none
module wait_counter
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// control
	input  wire logic       start,
	input  wire logic [3:0] states,
	// status
	output logic            busy
);
	logic [3:0] remain;

	always_ff @(posedge clock) begin
		if (reset)
			remain <= 4'h0;
		else if (start)
			// the cycle that leaves the wait state is itself a wait cycle
			remain <= 4'(states / 4'(STATES_PER_CLOCK)) - 4'h1;
		else if (remain != 4'h0)
			remain <= remain - 4'h1;
	end

	assign busy = remain != 4'h0;
endmodule
`default_nettype wire

// >>> testbench/ext_mem_model.sv
// behavioural memory chips behind the three selects
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
	// clock
	input  wire logic        clock,
	// bus pins
	input  wire logic [21:0] addr,
	input  wire logic        read_n,
	input  wire logic        write_n,
	input  wire logic [2:0]  sel_n,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [0:1023];
	logic [7:0] idle_pat = 8'h5a;
	logic [9:0] idx;
	logic       hit;
	assign hit = sel_n != 3'h7;
	assign idx = {!sel_n[0] ? 2'h0 : !sel_n[1] ? 2'h1 : 2'h2, addr[7:0]};
	// a released bus never repeats its last value
	assign rdata = (hit && !read_n) ? mem[idx] : idle_pat;
	always @(posedge clock) begin
		idle_pat <= ~idle_pat;
		if (hit && !write_n)
			mem[idx] <= wdata;
	end
endmodule
`default_nettype wire

// >>> testbench/ext_memory_bus_chk.sv
// concurrent checks on the external memory bus interface ports
`timescale 1ns/1ns
`default_nettype none
module ext_memory_bus_chk
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// configuration and requests
	input  wire logic        cpu_standby,
	input  wire logic [2:0]  select_enable,
	input  wire logic        access_start,
	input  wire logic        access_write,
	input  wire logic [23:0] access_addr,
	// outputs
	input  wire logic        access_done,
	input  wire logic [21:0] port_addr_data,
	input  wire logic [4:0]  port_ctl_data,
	input  wire bus_mode_t   bus_mode,
	input  wire logic [21:0] ext_addr_lines,
	input  wire logic        out_port_read_pin,
	input  wire logic        out_port_write_pin,
	input  wire logic        chip_select_zero_n,
	input  wire logic        chip_select_one_n,
	input  wire logic        chip_select_two_n
);
	logic        pend;
	logic        cur_int;
	logic        cur_wr;
	logic [23:0] cur_addr;
	logic [2:0]  sel_n;
	logic [4:0]  ctl_pins;
	assign sel_n = {chip_select_two_n, chip_select_one_n, chip_select_zero_n};
	assign ctl_pins = {sel_n, out_port_write_pin, out_port_read_pin};
	// tracks one transfer from acceptance to completion
	always_ff @(posedge clock) begin
		if (reset)
			pend <= 1'b0;
		else if (access_start && !pend)
			pend <= 1'b1;
		else if (access_done)
			pend <= 1'b0;
	end
	always_ff @(posedge clock) begin
		if (access_start && !pend) begin
			cur_addr <= access_addr;
			cur_wr <= access_write;
			cur_int <= access_addr[23:12] == 12'h00f;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	a_single_addr: assert property (
		bus_mode == MODE_SINGLE ##1
		(bus_mode == MODE_SINGLE && $stable(port_addr_data))
		|-> ext_addr_lines == port_addr_data)
		else $error("address pins differ from port data");
	a_upper_port: assert property (
		bus_mode == MODE_64K ##1
		(bus_mode == MODE_64K && $stable(port_addr_data))
		|-> ext_addr_lines[21:16] == port_addr_data[21:16])
		else $error("upper pins differ from port data");
	a_single_ctl: assert property (
		bus_mode == MODE_SINGLE ##1
		(bus_mode == MODE_SINGLE && $stable(port_ctl_data))
		|-> ctl_pins == port_ctl_data)
		else $error("control pins differ from port data");
	a_standby_high: assert property (
		$past(cpu_standby) && $past(bus_mode) != MODE_SINGLE
		|-> &(sel_n | ~$past(select_enable)))
		else $error("select low in standby");
	a_internal_quiet: assert property (
		pend && $past(pend) && cur_int && bus_mode != MODE_SINGLE
		|-> out_port_read_pin && out_port_write_pin
		&& &(sel_n | ~select_enable))
		else $error("strobe or select on internal access");
	a_addr_on_bus: assert property (
		pend && bus_mode != MODE_SINGLE
		&& !(out_port_read_pin && out_port_write_pin)
		|-> ext_addr_lines[15:0] == cur_addr[15:0])
		else $error("low address wrong during strobe");
	a_full_addr: assert property (
		pend && bus_mode inside {MODE_4M_MIN, MODE_4M_MAX}
		&& !(out_port_read_pin && out_port_write_pin)
		|-> ext_addr_lines == cur_addr[21:0])
		else $error("full address wrong during strobe");
	a_strobe_kind: assert property (
		pend && bus_mode != MODE_SINGLE
		|-> (cur_wr ? out_port_read_pin : out_port_write_pin))
		else $error("wrong strobe for transfer");
	a_done_pulse: assert property (
		access_done |=> !access_done)
		else $error("done longer than one cycle");
	a_done_bound: assert property (
		access_start && !pend |-> ##[3:12] access_done)
		else $error("transfer not completed in time");
	c_ext_read: cover property (pend && !cur_wr && !out_port_read_pin);
	c_ext_write: cover property (pend && cur_wr && !out_port_write_pin);
	c_standby: cover property (cpu_standby && access_done);
endmodule
bind ext_memory_bus ext_memory_bus_chk chk (.clock, .reset, .cpu_standby,
	.select_enable, .access_start, .access_write, .access_addr,
	.access_done, .port_addr_data, .port_ctl_data, .bus_mode,
	.ext_addr_lines, .out_port_read_pin, .out_port_write_pin,
	.chip_select_zero_n, .chip_select_one_n, .chip_select_two_n);
`default_nettype wire

// >>> testbench/ext_memory_bus_tb.sv
// self-checking bench for the external memory bus interface
`timescale 1ns/1ns
`default_nettype none
module ext_memory_bus_tb;
	import ext_bus_pkg::*;
	logic clock, reset, external_rom_mode, low_speed_osc_clock, cpu_standby;
	logic access_start, access_write, access_done, out_port_read_pin;
	logic out_port_write_pin, chip_select_zero_n, chip_select_one_n;
	logic chip_select_two_n;
	logic [1:0] wait_choice;
	logic [2:0] select_enable;
	logic [5:0] we;
	logic [71:0] pw;
	logic [23:0] access_addr;
	logic [7:0] access_wdata, access_rdata, io_port_data, io_port_dir;
	logic [7:0] ext_data_lines_out;
	wire [7:0] ext_data_lines_in;
	logic [21:0] port_addr_data, port_addr_hiz, ext_addr_lines;
	logic [4:0] port_ctl_data, port_ctl_hiz;
	bus_mode_t requested_mode, bus_mode;
	dec_size_t dec_size;
	int failures, checked;
	wire [4:0] ctl_pins = {chip_select_two_n, chip_select_one_n,
		chip_select_zero_n, out_port_write_pin, out_port_read_pin};
	wire [69:0] regs = {io_port_dir, io_port_data, port_ctl_hiz,
		port_ctl_data, port_addr_hiz, port_addr_data};
	// {mode, external rom, size}
	logic [4:0] cfgs [9] = '{5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e,
		5'h0f, 5'h10, 5'h1c};
	logic [23:0] corner [13] = '{24'h00_0000, 24'h00_1fff, 24'h00_6fff,
		24'h00_7000, 24'h00_8000, 24'h00_a000, 24'h00_b000, 24'h00_c000,
		24'h00_efff, 24'h00_f000, 24'h3f_ffff, 24'h7f_ffff, 24'hc0_0000};
	ext_memory_bus dut (.clock, .reset, .requested_mode, .external_rom_mode,
		.select_enable, .dec_size, .wait_choice, .low_speed_osc_clock,
		.cpu_standby, .access_start, .access_write, .access_addr,
		.access_wdata, .access_done, .access_rdata,
		.port_addr_we(we[0]), .port_addr_wdata(pw[21:0]),
		.port_addr_hiz_we(we[1]), .port_addr_hiz_wdata(pw[43:22]),
		.port_ctl_we(we[2]), .port_ctl_wdata(pw[48:44]),
		.port_ctl_hiz_we(we[3]), .port_ctl_hiz_wdata(pw[53:49]),
		.io_port_we(we[4]), .io_port_wdata(pw[61:54]),
		.io_port_dir_we(we[5]), .io_port_dir_wdata(pw[69:62]),
		.port_addr_data, .port_addr_hiz, .port_ctl_data, .port_ctl_hiz,
		.io_port_data, .io_port_dir, .bus_mode, .ext_addr_lines,
		.ext_addr_lines_oe(), .out_port_read_pin, .out_port_write_pin,
		.strobe_pins_oe(), .chip_select_zero_n, .chip_select_one_n,
		.chip_select_two_n, .select_pins_oe(), .ext_data_lines_in,
		.ext_data_lines_out, .ext_data_lines_oe());
	ext_mem_model mem (.clock, .addr(ext_addr_lines),
		.read_n(out_port_read_pin), .write_n(out_port_write_pin),
		.sel_n(ctl_pins[4:2]), .wdata(ext_data_lines_out),
		.rdata(ext_data_lines_in));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// one-hot select expected for {mode, rom, size} and an address
	function automatic logic [2:0] exp_sel(input logic [4:0] c,
		input logic [23:0] a);
		logic [23:0] lo;
		int n;
		int lim;
		if (a[23:12] == 12'h00f)
			return 3'h0;
		if (c[4:3] != 2'h1)
			case (a[23:22])
				2'h1: return 3'h2;
				2'h2: return 3'h4;
				2'h3: return {2'h0, !c[2]};
				default: return {2'h0, c[2]};
			endcase
		lo = c[2] ? 24'h00_0000 : c[1:0] == 2'h1 ? 24'h00_7000 : 24'h00_8000;
		lim = c[2] ? 3 : 3 - c[1:0];
		if (a > 24'h00_efff || a < lo)
			return 3'h0;
		n = (a - lo) / (24'h00_2000 << c[1:0]);
		return n < lim ? 3'(1 << n) : 3'h0;
	endfunction
	task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic poke;
		@(posedge clock);
		we <= 6'h3f;
		pw <= {8'h00, $urandom, $urandom};
		@(posedge clock);
		we <= 6'h00;
		repeat (2) @(negedge clock);
		cmp(regs, pw[69:0]);
	endtask
	task automatic xfer(input logic w, input logic [23:0] a,
		input logic [7:0] d, output int lat, output logic [2:0] seen);
		repeat (2) @(posedge clock);
		access_start <= 1'b1;
		access_write <= w;
		access_addr <= a;
		access_wdata <= d;
		@(posedge clock);
		access_start <= 1'b0;
		seen = 3'h0;
		for (lat = 1; lat < 30; lat++) begin
			@(negedge clock);
			seen |= ~ctl_pins[4:2];
			if (access_done === 1'b1)
				break;
		end
		if (lat == 30) begin
			failures++;
			close_out();
		end
	endtask
	initial begin
		logic [7:0]  d;
		logic [2:0]  seen;
		logic [2:0]  e;
		logic [23:0] a;
		int          lat;
		d = 8'($urandom(44));
		reset = 1'b1;
		requested_mode = MODE_SINGLE;
		external_rom_mode = 1'b0;
		select_enable = 3'h7;
		dec_size = SIZE_8K;
		wait_choice = 2'h0;
		low_speed_osc_clock = 1'b0;
		cpu_standby = 1'b0;
		access_start = 1'b0;
		access_write = 1'b0;
		access_addr = 24'h00_0000;
		access_wdata = 8'h00;
		we = 6'h00;
		pw = 72'h0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		cmp(bus_mode, MODE_SINGLE);
		cmp(ctl_pins, 5'h1f);
		poke();
		cmp(ext_addr_lines, pw[21:0]);
		cmp(ctl_pins, pw[48:44]);
		foreach (cfgs[i]) begin
			@(posedge clock);
			requested_mode <= bus_mode_t'(cfgs[i][4:3]);
			external_rom_mode <= cfgs[i][2];
			dec_size <= dec_size_t'(cfgs[i][1:0]);
			select_enable <= 3'($urandom);
			wait_choice <= 2'($urandom);
			poke();
			for (int j = 0; j < 19; j++) begin
				a = j < 13 ? corner[j] : 24'($urandom);
				if (cfgs[i][4:3] == 2'h1)
					a[23:16] = 8'h00;
				e = exp_sel(cfgs[i], a) & select_enable;
				d = 8'($urandom);
				xfer(1'b1, a, d, lat, seen);
				cmp(seen & select_enable, e);
				xfer(1'b0, a, 8'h00, lat, seen);
				cmp(seen & select_enable, e);
				if (e != 3'h0)
					cmp(access_rdata, d);
			end
		end
		@(posedge clock);
		requested_mode <= MODE_SINGLE;
		repeat (2) @(posedge clock);
		@(negedge clock);
		cmp(bus_mode, MODE_4M_MAX);
		@(posedge clock);
		requested_mode <= MODE_4M_MAX;
		select_enable <= 3'h7;
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			wait_choice <= 2'(k);
			low_speed_osc_clock <= k[2];
			xfer(1'b0, 24'h40_0010, 8'h00, lat, seen);
			cmp(lat, 4 + ((k > 3 || k == 0) ? 0 : 2 * k));
			xfer(1'b0, 24'h00_f010, 8'h00, lat, seen);
			cmp(lat, 4);
		end
		@(posedge clock);
		cpu_standby <= 1'b1;
		xfer(1'b0, 24'h80_0000, 8'h00, lat, seen);
		cmp(seen, 3'h0);
		@(posedge clock);
		cpu_standby <= 1'b0;
		external_rom_mode <= 1'b0;
		requested_mode <= MODE_SINGLE;
		wait_choice <= 2'h3;
		xfer(1'b0, 24'h00_8000, 8'h00, lat, seen);
		cmp(lat, 4);
		close_out();
	end
endmodule
`default_nettype wire
